// ---- pkg/spf_pkg.sv ----
// Package of constants and carrier types for the self-program flash control block.
package spf_pkg;

  // ---------------------------------------------------------------------------
  // Register map and field positions
  // ---------------------------------------------------------------------------
  localparam logic [5:0] REG_ADDR      = 6'h37;  // I/O address of the control register.
  localparam logic [7:0] REG_RESET     = 8'h00;  // Value after reset.
  localparam int         BIT_IRQ_EN    = 7;      // Ready interrupt enable.
  localparam int         BIT_BUSY      = 6;      // Region busy flag.
  localparam int         BIT_RESERVED  = 5;      // Reserved, reads zero.
  localparam int         BIT_REENABLE  = 4;      // Region read re-enable.
  localparam int         BIT_LOCK_SEL  = 3;      // Lock/fuse read select.
  localparam int         BIT_PAGE_WR   = 2;      // Page write command.
  localparam int         BIT_PAGE_ER   = 1;      // Page erase command.
  localparam int         BIT_ENABLE    = 0;      // Self-program enable.

  // ---------------------------------------------------------------------------
  // Legal command patterns in the lower five bits
  // ---------------------------------------------------------------------------
  localparam logic [4:0] CMD_REENABLE  = 5'h11;  // 10001.
  localparam logic [4:0] CMD_LOCK_RD   = 5'h09;  // 01001.
  localparam logic [4:0] CMD_PAGE_WR   = 5'h05;  // 00101.
  localparam logic [4:0] CMD_PAGE_ER   = 5'h03;  // 00011.
  localparam logic [4:0] CMD_FILL      = 5'h01;  // 00001.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam logic [2:0] STORE_WINDOW  = 3'h4;   // Cycles a store may follow the enable.
  localparam logic [2:0] LOAD_WINDOW   = 3'h3;   // Cycles a load may follow the enable.
  localparam int         CLK_MHZ       = 100;    // Clock rate.
  localparam int         PROG_TIME_US  = 4500;   // Longest flash operation time in microseconds.
  localparam int         PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;  // Operation length in cycles.

  // ---------------------------------------------------------------------------
  // Flash geometry
  // ---------------------------------------------------------------------------
  localparam int         PAGE_WORDS    = 64;     // Words in one page buffer.
  localparam int         PAGE_IDX_W    = 6;      // Width of a word index within a page.
  localparam logic [15:0] NO_READ_WHILE_WRITE_REGION_START   = 16'h7000; // First byte address of the no-READ_WHILE_WRITE_REGION region.
  localparam logic [1:0] LOCK_INFO_SEL = 2'h1;   // Low pointer bits that pick the lock bits.

  // Flash operation kind.
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE} spf_op_e;

  // Request from the control block to the flash array.
  typedef struct packed {
    logic                  start;   // One-cycle start pulse.
    spf_op_e               op;      // Erase or write.
    logic [15:0]           addr;    // Byte address of the page.
  } spf_flash_req_s;

endpackage

// ---- rtl/spf_ctrl.sv ----
// Self-program flash control: control register, command windows, page buffer, region logic.
//
// Notes on behaviour
// - Ready irq when enable bit and global flag
// - No ready irq during eeprom or store
// - Smallest variant: busy flag reads zero
// - Bit five reads as zero
// - Re-enable during fill clears page buffer
// - Load within three cycles returns lock/fuse
// - Page write stores buffer to page
// - Page write bit clears on done/timeout
// - Page erase erases addressed page
// - Page erase bit clears on done/timeout
// - Enable allows store for four cycles
// - Plain enable store fills buffer word
// - Enable clears after store or timeout
// - Illegal command patterns are ignored
// - Stores from application region are disabled
// - Boot stores may target any address
// - Boot size fuses split application/boot
// - READ_WHILE_WRITE_REGION programming keeps NO_READ_WHILE_WRITE_REGION readable
// - NO_READ_WHILE_WRITE_REGION programming halts the CPU
// - Busy flag high until re-enable or a NO_READ_WHILE_WRITE_REGION page operation
// - Boot region lies inside NO_READ_WHILE_WRITE_REGION
module spf_ctrl #(
  parameter int PROG_CYCLES_P = spf_pkg::PROG_CYCLES,  // Flash operation length in cycles.
  parameter bit SMALL_VARIANT = 1'b0                   // Busy flag reads zero in the register; rww_blocked still follows it.
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  // I/O register port from the core
  input  wire logic [5:0]             io_addr,
  input  wire logic                   io_wr,
  input  wire logic [7:0]             io_wdata,
  output logic [7:0]                  io_rdata,
  // Store and load program instructions
  input  wire logic                   store_exec,
  input  wire logic                   load_exec,
  input  wire logic [15:0]            pointer,
  input  wire logic [15:0]            data_word_pair,
  input  wire logic [15:0]            exec_pc,
  // System state
  input  wire logic                   global_irq_flag,
  input  wire logic                   eeprom_busy,
  input  wire logic [1:0]             boot_size_fuses,
  input  wire logic [7:0]             lock_bits,
  input  wire logic [7:0]             fuse_bits,
  // Flash array
  input  wire logic                   flash_done,
  output spf_pkg::spf_flash_req_s     flash_req,
  output logic [15:0]                 buf_rdata,
  input  wire logic [5:0]             buf_raddr,
  // Results to the core
  output logic                        load_override,
  output logic [7:0]                  load_data,
  output logic                        cpu_halt,
  output logic                        rww_blocked,
  output logic                        store_ready_irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} spf_state_e;

  // State of the block, apart from the page buffer and its read port, in one record.
  typedef struct packed {
    spf_state_e              st;        // Sequencer state.
    logic                    irq_en;    // Ready interrupt enable.
    logic                    busy;      // Region busy flag.
    logic [4:0]              cmd;       // Command bits 4..0.
    logic [2:0]              win;       // Cycles left in the window.
    logic                    filling;   // Page buffer holds data.
    logic                    no_read_while_write_region_op;   // Running operation targets NO_READ_WHILE_WRITE_REGION.
    logic [31:0]             tmr;       // Operation timer.
    spf_pkg::spf_flash_req_s req;       // Request to the flash array.
    logic [7:0]              rdata;     // Read data of the register port.
    logic                    lovr;      // Load override valid.
    logic [7:0]              ldata;     // Lock or fuse byte.
    logic                    halt;      // Core halt.
    logic                    irq;       // Ready interrupt.
  } spf_state_s;

  spf_state_s r;        // Registered state.
  spf_state_s next_r;   // Next state.

  // Page buffer memory and its write controls.
  logic [15:0] page_buf [spf_pkg::PAGE_WORDS];
  logic        buf_we;                          // Store a word this cycle.
  logic        buf_clr;                         // Discard buffer contents.
  logic [15:0] boot_start;                      // First byte of the boot region.
  logic        from_boot;                       // Store comes from boot code.
  logic        tgt_no_read_while_write_region;                        // Target page lies in NO_READ_WHILE_WRITE_REGION.
  logic        reg_wr;                          // Write to the control register.
  logic        legal;                           // Written pattern is a legal command.

  // ---------------------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------------------
  // The boot size fuses choose the boot region start; every choice is at or above the
  // NO_READ_WHILE_WRITE_REGION start so the boot region always sits inside NO_READ_WHILE_WRITE_REGION.
  always_comb
  begin
    case (boot_size_fuses)
      2'h0:    boot_start = 16'h7000;
      2'h1:    boot_start = 16'h7800;
      2'h2:    boot_start = 16'h7C00;
      default: boot_start = 16'h7E00;
    endcase
  end

  // Only code in the boot region may start programming; the target is unrestricted.
  assign from_boot = (exec_pc >= boot_start);
  assign tgt_no_read_while_write_region  = (pointer >= spf_pkg::NO_READ_WHILE_WRITE_REGION_START);
  assign reg_wr    = io_wr && (io_addr == spf_pkg::REG_ADDR);
  assign legal     = (io_wdata[4:0] == spf_pkg::CMD_REENABLE) ||
                     (io_wdata[4:0] == spf_pkg::CMD_LOCK_RD) ||
                     (io_wdata[4:0] == spf_pkg::CMD_PAGE_WR) ||
                     (io_wdata[4:0] == spf_pkg::CMD_PAGE_ER) ||
                     (io_wdata[4:0] == spf_pkg::CMD_FILL);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Decodes register writes, counts the windows and sequences flash operations.
  always_comb
  begin
    next_r = r;
    buf_we = 1'b0;
    buf_clr = 1'b0;
    next_r.req.start = 1'b0;
    next_r.lovr = 1'b0;
    case (r.st)
      ST_IDLE:
      begin
        // Register writes act only while idle; illegal patterns leave command bits.
        if (reg_wr)
        begin
          next_r.irq_en = io_wdata[spf_pkg::BIT_IRQ_EN];
          if (legal)
          begin
            next_r.cmd = io_wdata[4:0];
            next_r.win = spf_pkg::STORE_WINDOW;
            next_r.st  = ST_ARMED;
            if (io_wdata[4:0] == spf_pkg::CMD_REENABLE && r.filling)
            begin
              buf_clr = 1'b1;
              next_r.filling = 1'b0;
            end
          end
        end
      end
      ST_ARMED:
      begin
        // The load window is one cycle shorter than the store window.
        if (load_exec && r.cmd == spf_pkg::CMD_LOCK_RD &&
            (spf_pkg::STORE_WINDOW - r.win) < spf_pkg::LOAD_WINDOW)
        begin
          next_r.lovr  = 1'b1;
          next_r.ldata = (pointer[1:0] == spf_pkg::LOCK_INFO_SEL) ? lock_bits : fuse_bits;
          next_r.cmd   = 5'h00;
          next_r.st    = ST_IDLE;
        end
        else if (store_exec && from_boot)
        begin
          case (r.cmd)
            spf_pkg::CMD_FILL:
            begin
              buf_we = 1'b1;
              next_r.filling = 1'b1;
              next_r.cmd = 5'h00;
              next_r.st  = ST_IDLE;
            end
            spf_pkg::CMD_REENABLE:
            begin
              next_r.busy = 1'b0;
              next_r.cmd = 5'h00;
              next_r.st  = ST_IDLE;
            end
            spf_pkg::CMD_PAGE_WR, spf_pkg::CMD_PAGE_ER:
            begin
              // Register data is ignored; the page comes from the upper pointer bits.
              next_r.req.start = 1'b1;
              next_r.req.op   = (r.cmd == spf_pkg::CMD_PAGE_WR) ?
                                spf_pkg::OP_WRITE : spf_pkg::OP_ERASE;
              next_r.req.addr = {pointer[15:1], 1'b0};
              next_r.no_read_while_write_region_op  = tgt_no_read_while_write_region;
              next_r.halt     = tgt_no_read_while_write_region;
              next_r.busy     = !tgt_no_read_while_write_region;
              next_r.tmr      = 32'h0000_0000;
              next_r.st       = ST_BUSY;
            end
            default:
            begin
              next_r.cmd = 5'h00;
              next_r.st  = ST_IDLE;
            end
          endcase
        end
        else if (r.win == 3'h1)
        begin
          next_r.cmd = 5'h00;
          next_r.st  = ST_IDLE;
        end
        else
        begin
          next_r.win = r.win - 3'h1;
        end
      end
      ST_BUSY:
      begin
        // Enable and command bit stay high until the array reports completion or the timer expires.
        next_r.tmr = r.tmr + 32'h0000_0001;
        if (flash_done || r.tmr == 32'(PROG_CYCLES_P - 1))
        begin
          if (r.req.op == spf_pkg::OP_WRITE)
          begin
            buf_clr = 1'b1;
            next_r.filling = 1'b0;
          end
          next_r.cmd  = 5'h00;
          next_r.halt = 1'b0;
          next_r.req.op = spf_pkg::OP_NONE;
          next_r.st   = ST_IDLE;
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase
    // Ready interrupt only when idle, enabled, and no eeprom write in progress.
    next_r.irq = next_r.irq_en && global_irq_flag && !next_r.cmd[0] &&
                 next_r.st == ST_IDLE && !eeprom_busy;
    next_r.rdata = {next_r.irq_en,
                    next_r.busy && !SMALL_VARIANT,
                    1'b0,
                    next_r.cmd};
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Registers the whole state record.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Page buffer words; a clear leaves every word all ones, like erased cells.
  for (genvar i = 0; i < spf_pkg::PAGE_WORDS; i++)
  begin : g_buf
    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
      begin
        page_buf[i]  <= 16'h0000;
      end
      else if (buf_clr)
      begin
        page_buf[i]  <= 16'hFFFF;
      end
      else if (buf_we && pointer[6:1] == spf_pkg::PAGE_IDX_W'(i))
      begin
        page_buf[i]  <= data_word_pair;
      end
    end
  end

  // Registered buffer read port for the flash array.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      buf_rdata <= 16'h0000;
    end
    else
    begin
      buf_rdata <= page_buf[buf_raddr];
    end
  end

  // Outputs straight from state flip-flops.
  assign io_rdata        = r.rdata;
  assign flash_req       = r.req;
  assign load_override   = r.lovr;
  assign load_data       = r.ldata;
  assign cpu_halt        = r.halt;
  assign rww_blocked     = r.busy;
  assign store_ready_irq = r.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    io_rdata[spf_pkg::BIT_RESERVED] == 1'b0) else $error("reserved bit reads one");

  a_window_ends: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && legal && r.st == ST_IDLE) ##1 (!store_exec && !load_exec) [*4]
    |=> io_rdata[spf_pkg::BIT_ENABLE] == 1'b0) else $error("enable not cleared");

  a_illegal_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && !legal && r.st == ST_IDLE) |=> $stable(r.cmd)) else $error("illegal write acted");

  a_app_store_none: assert property (@(posedge mclk) disable iff (!resetn)
    (store_exec && !from_boot) |=> !flash_req.start) else $error("store from app");

  a_no_window_none: assert property (@(posedge mclk) disable iff (!resetn)
    (store_exec && r.st == ST_IDLE) |-> !buf_we ##1 !flash_req.start) else $error("store no window");

  a_irq_blocked: assert property (@(posedge mclk) disable iff (!resetn)
    (r.st == ST_BUSY) |-> !store_ready_irq) else $error("irq during store");

  a_no_read_while_write_region_halts: assert property (@(posedge mclk) disable iff (!resetn)
    (flash_req.start && r.no_read_while_write_region_op) |-> cpu_halt && r.st == ST_BUSY) else $error("no halt");

  a_rww_runs: assert property (@(posedge mclk) disable iff (!resetn)
    (flash_req.start && !r.no_read_while_write_region_op) |-> !cpu_halt ##1 rww_blocked) else $error("rww halted");

  a_enable_held: assert property (@(posedge mclk) disable iff (!resetn)
    (r.st == ST_BUSY) |-> io_rdata[spf_pkg::BIT_ENABLE]) else $error("enable dropped early");

  a_lock_read: assert property (@(posedge mclk) disable iff (!resetn)
    (r.st == ST_ARMED && r.cmd == spf_pkg::CMD_LOCK_RD && load_exec && r.win > 3'h1)
    |=> load_override) else $error("lock read missed");

  a_busy_cleared: assert property (@(posedge mclk) disable iff (!resetn)
    (r.st == ST_ARMED && r.cmd == spf_pkg::CMD_REENABLE && store_exec && from_boot)
    |=> !rww_blocked) else $error("busy not cleared");

  a_buffer_cleared: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && r.st == ST_IDLE && io_wdata[4:0] == spf_pkg::CMD_REENABLE && r.filling)
    |-> ##2 buf_rdata == 16'hFFFF) else $error("buffer not cleared");

endmodule

// ---- verification/spf_cpu_model.sv ----
// Behavioural model of the core that writes the control register and runs store/load ops.
module spf_cpu_model (
  // Clock
  input  wire logic        mclk,
  // Register and instruction signals towards the block
  output logic [5:0]       io_addr,
  output logic             io_wr,
  output logic [7:0]       io_wdata,
  output logic             store_exec,
  output logic             load_exec,
  output logic [15:0]      pointer,
  output logic [15:0]      data_word_pair,
  output logic [15:0]      exec_pc
);
  timeunit 1ns;
  timeprecision 1ps;

  // Code starts at 0x7800, never in the region being programmed; a store can name another pc.
  initial
  begin
    io_addr        = spf_pkg::REG_ADDR;
    io_wr          = 1'b0;
    io_wdata       = 8'h00;
    store_exec     = 1'b0;
    load_exec      = 1'b0;
    pointer        = 16'h0000;
    data_word_pair = 16'h0000;
    exec_pc        = 16'h7800;
  end

  // Register write: held for one rising edge, launched and released on falling edges.
  task automatic wr_reg(input logic [7:0] val);
    io_wdata = val;
    io_wr    = 1'b1;
    @(negedge mclk);
    io_wr    = 1'b0;
  endtask

  // Write aimed at the next I/O address, which the control register must ignore.
  task automatic wr_other(input logic [7:0] val);
    io_addr = spf_pkg::REG_ADDR + 6'h01;
    wr_reg(val);
    io_addr = spf_pkg::REG_ADDR;
  endtask

  // Store instruction issued on the first rising edge after the call.
  task automatic store(input logic [15:0] ptr, input logic [15:0] dat, input logic [15:0] pc);
    pointer        = ptr;
    data_word_pair = dat;
    exec_pc        = pc;
    store_exec     = 1'b1;
    @(negedge mclk);
    store_exec     = 1'b0;
    data_word_pair = ~dat;
    exec_pc        = 16'h7800;
  endtask

  // Load instruction issued on the first rising edge after the call.
  task automatic load(input logic [15:0] ptr);
    pointer   = ptr;
    load_exec = 1'b1;
    @(negedge mclk);
    load_exec = 1'b0;
  endtask
endmodule

// ---- verification/test_self_program_flash_control.sv ----
// Self-checking testbench for the self-program flash control block.
module test_self_program_flash_control;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                    mclk, resetn, global_irq_flag, eeprom_busy, flash_done;
  logic [5:0]              io_addr, buf_raddr;
  logic                    io_wr, store_exec, load_exec;
  logic [7:0]              io_wdata, io_rdata, lock_bits, fuse_bits, load_data;
  logic [15:0]             pointer, data_word_pair, exec_pc, buf_rdata;
  logic [1:0]              boot_size_fuses;
  logic                    load_override, cpu_halt, rww_blocked, store_ready_irq;
  spf_pkg::spf_flash_req_s flash_req;
  int                      miscompares, num_checks, cycles;
  logic [4:0]              op_cnt;

  spf_cpu_model cpu (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
    .store_exec(store_exec), .load_exec(load_exec), .pointer(pointer),
    .data_word_pair(data_word_pair), .exec_pc(exec_pc));

  spf_ctrl #(.PROG_CYCLES_P(20)) dut (.mclk(mclk), .resetn(resetn), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .store_exec(store_exec),
    .load_exec(load_exec), .pointer(pointer), .data_word_pair(data_word_pair),
    .exec_pc(exec_pc), .global_irq_flag(global_irq_flag), .eeprom_busy(eeprom_busy),
    .boot_size_fuses(boot_size_fuses), .lock_bits(lock_bits), .fuse_bits(fuse_bits),
    .flash_done(flash_done), .flash_req(flash_req), .buf_rdata(buf_rdata),
    .buf_raddr(buf_raddr), .load_override(load_override), .load_data(load_data),
    .cpu_halt(cpu_halt), .rww_blocked(rww_blocked), .store_ready_irq(store_ready_irq));

  // Clock of 10 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Flash array stand-in: answers each start with a done pulse ten cycles later.
  always @(negedge mclk)
  begin
    flash_done = 1'b0;
    if (!resetn)
      op_cnt = 5'd0;
    else if (flash_req.start === 1'b1)
      op_cnt = 5'd10;
    else if (op_cnt != 5'd0)
    begin
      op_cnt = op_cnt - 5'd1;
      flash_done = (op_cnt == 5'd0);
    end
  end

  // Hang guard: a run far longer than all scenarios is cut short.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Waits a number of falling edges.
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Page write into the no-READ_WHILE_WRITE_REGION region halts the core until done, then bits clear.
  task automatic scen_page_write();
    cpu.wr_reg(8'h05);
    cpu.store(16'h7100, 16'h1234, 16'h7800);
    check(io_rdata[2:0], 3'b101, "command bits");
    check({flash_req.start, 6'h00, flash_req.op}, {1'b1, 6'h00, 2'h2}, "write start");
    check(cpu_halt, 1'b1, "halt on write");
    @(negedge mclk);
    idle(5);
    check(io_rdata[0], 1'b1, "enable held");
    idle(10);
    check({io_rdata[2:0], cpu_halt}, 4'h0, "after write");
  endtask

  // Page erase in the READ_WHILE_WRITE_REGION region: core runs, busy flag set until re-enable.
  task automatic scen_erase_rww();
    cpu.wr_reg(8'h03);
    cpu.store(16'h1000, 16'h0000, 16'h7800);
    check({flash_req.start, flash_req.op, cpu_halt}, {1'b1, 2'h1, 1'b0}, "erase");
    check(rww_blocked, 1'b1, "blocked");
    @(negedge mclk);
    idle(15);
    check({io_rdata[6], io_rdata[1]}, 2'b10, "busy after erase");
    cpu.wr_reg(8'h11);
    cpu.store(16'h0000, 16'h0000, 16'h7800);
    idle(2);
    check({io_rdata[6], rww_blocked}, 2'b00, "re-enabled");
  endtask

  // No store within the window: bits clear, late store does nothing.
  task automatic scen_timeout();
    cpu.wr_reg(8'h05);
    idle(5);
    check(io_rdata[2:0], 3'b000, "window lapsed");
    cpu.store(16'h7100, 16'h0000, 16'h7800);
    check(flash_req.start, 1'b0, "late store");
    @(negedge mclk);
  endtask

  // Stores from below the boot start are refused; the boot start follows the fuses.
  task automatic scen_app_store();
    cpu.wr_reg(8'h05);
    cpu.store(16'h7100, 16'h0000, 16'h0100);
    check(flash_req.start, 1'b0, "app store");
    boot_size_fuses = 2'h2;
    idle(1);
    cpu.store(16'h7100, 16'h0000, 16'h7800);
    check(flash_req.start, 1'b0, "below moved boot start");
    boot_size_fuses = 2'h1;
    idle(5);
  endtask

  // Illegal patterns, reserved bit and the ready interrupt.
  task automatic scen_reg_irq();
    cpu.wr_reg(8'h87);
    idle(1);
    check(io_rdata, 8'h80, "illegal pattern");
    cpu.wr_reg(8'hA0);
    idle(1);
    check(io_rdata, 8'h80, "reserved bit");
    cpu.wr_other(8'h01);
    idle(1);
    check(io_rdata, 8'h80, "other address");
    global_irq_flag = 1'b1;
    idle(2);
    check(store_ready_irq, 1'b1, "irq raised");
    eeprom_busy = 1'b1;
    idle(2);
    check(store_ready_irq, 1'b0, "irq during eeprom");
    eeprom_busy = 1'b0;
    cpu.wr_reg(8'h00);
    idle(2);
    check(store_ready_irq, 1'b0, "irq masked");
  endtask

  // Lock and fuse readback by pointer low bits.
  task automatic scen_lock_read();
    cpu.wr_reg(8'h09);
    cpu.load(16'h0001);
    check({load_override, load_data}, {1'b1, 8'hC3}, "lock bits");
    idle(4);
    fuse_bits = 8'hA5;
    cpu.wr_reg(8'h09);
    idle(2);
    cpu.load(16'h0000);
    check({load_override, load_data}, {1'b1, 8'hA5}, "fuse bits");
    idle(4);
    cpu.wr_reg(8'h09);
    idle(3);
    cpu.load(16'h0001);
    check(load_override, 1'b0, "late load");
  endtask

  // Buffer fill ignores pointer bit zero; re-enable during fill clears it.
  task automatic scen_fill();
    cpu.wr_reg(8'h01);
    cpu.store(16'h0005, 16'hBEEF, 16'h7800);
    buf_raddr = 6'h02;
    idle(2);
    check(buf_rdata, 16'hBEEF, "filled word");
    check(io_rdata[0], 1'b0, "enable after fill");
    cpu.wr_reg(8'h11);
    cpu.store(16'h0000, 16'h0000, 16'h7800);
    idle(2);
    check(buf_rdata, 16'hFFFF, "cleared buffer");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    miscompares = 0;
    num_checks = 0;
    resetn = 1'b0;
    global_irq_flag = 1'b0;
    eeprom_busy = 1'b0;
    boot_size_fuses = 2'h1;
    lock_bits = 8'hC3;
    fuse_bits = 8'h5A;
    buf_raddr = 6'h00;
    idle(16);
    resetn = 1'b1;
    idle(2);
    check(io_rdata, spf_pkg::REG_RESET, "reset value");
    scen_page_write();
    scen_erase_rww();
    scen_timeout();
    scen_app_store();
    scen_reg_irq();
    scen_lock_read();
    scen_fill();
    complete_run();
  end
endmodule
